// ---- rtl/ccs_pkg.sv ----
// package: register map, field layout, reset values and timing for the clamp/coast control block
package ccs_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CLAMP_PLACE = 6'h05;
  localparam logic [5:0] IDX_CLAMP_DUR = 6'h06;
  localparam logic [5:0] IDX_CTRL = 6'h0f;
  localparam logic [5:0] IDX_SLICER = 6'h10;
  localparam logic [5:0] IDX_SEP_LIMIT = 6'h11;
  localparam logic [5:0] IDX_LEAD = 6'h12;
  localparam logic [5:0] IDX_TRAIL = 6'h13;

  // clamp_coast_power_ctrl fields
  localparam int B_CLAMP_EXT = 7;
  localparam int B_CLAMP_POL_LOW = 6;
  localparam int B_COAST_VSYNC = 5;
  localparam int B_COAST_POL_OVR = 4;
  localparam int B_COAST_POL_HIGH = 3;
  localparam int B_SEEK_ALLOW = 2;
  localparam int B_CHIP_SLEEP = 1;

  // green_slicer_clamp_cfg fields
  localparam int B_SLICER_LSB = 3;
  localparam int W_SLICER = 5;
  localparam int B_RED_MID = 2;
  localparam int B_BLUE_MID = 1;

  // reset values
  localparam logic [7:0] RST_CTRL = 8'h4e;
  localparam logic [7:0] RST_SLICER = 8'h78;
  localparam logic [7:0] RST_SEP_LIMIT = 8'h20;
  localparam logic [7:0] RST_LEAD = 8'h00;
  localparam logic [7:0] RST_TRAIL = 8'h00;
  localparam logic [7:0] RST_CLAMP_PLACE = 8'h08;
  localparam logic [7:0] RST_CLAMP_DUR = 8'h14;

  // timing: 125 MHz system clock, 5 MHz separator tick
  localparam int CLK_HZ = 125_000_000;
  localparam int SEP_TICK_HZ = 5_000_000;
  localparam int SEP_DIV = CLK_HZ / SEP_TICK_HZ;

  // settings as seen by the sync, clamp and coast logic
  typedef struct packed {
    logic clamp_ext;
    logic clamp_pol_low;
    logic coast_vsync;
    logic coast_pol_ovr;
    logic coast_pol_high;
    logic seek_allow;
    logic chip_sleep_bit;
    logic [W_SLICER-1:0] slicer;
    logic red_mid;
    logic blue_mid;
    logic [7:0] sep_limit;
    logic [7:0] lead;
    logic [7:0] trail;
    logic [7:0] place;
    logic [7:0] dur;
  } cfg_t;

  typedef enum logic [1:0] {
    CL_IDLE,
    CL_PLACE,
    CL_HOLD
  } clamp_st_t;

endpackage : ccs_pkg

// ---- rtl/sync_separator.sv ----
// sync separator: times input level in ticks of a divided clock
`timescale 1ns/1ps
module sync_separator
  import ccs_pkg::*;
#(
  parameter int DIV = SEP_DIV
) (
  input wire logic clk_i, // system clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic sync_i, // composite sync, same clock domain
  input wire logic [7:0] limit_i, // tick count before toggling
  output logic sep_o // separated sync
);

  initial begin
    if (DIV < 2 || DIV > 256) begin
      $error("sync_separator: DIV must lie between 2 and 256");
    end
  end

  logic [7:0] div_r;
  logic tick_r;
  logic [7:0] cnt_r;
  logic in_d_r;

  wire div_wrap = (div_r == 8'(DIV - 1));
  wire changed = (sync_i != in_d_r);
  wire reached = (cnt_r == limit_i);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_r <= 8'h00;
      tick_r <= 1'b0;
      cnt_r <= 8'h00;
      in_d_r <= 1'b0;
      sep_o <= 1'b0;
    end else begin
      div_r <= div_wrap ? 8'h00 : div_r + 8'h01;
      tick_r <= div_wrap;
      in_d_r <= sync_i;
      if (changed) begin
        cnt_r <= 8'h00;
      end else if (tick_r && !reached) begin
        cnt_r <= cnt_r + 8'h01; // [R11]
      end
      if (reached && !changed) begin
        sep_o <= in_d_r; // [R11]
      end
    end
  end

  property p_sep_follow;
    @(posedge clk_i) disable iff (!arst_n_i)
      (reached && !changed) |=> (sep_o == $past(in_d_r));
  endproperty
  a_sep_follow: assert property (p_sep_follow) else $error("separator did not toggle"); // [R11]

  property p_sep_hold;
    @(posedge clk_i) disable iff (!arst_n_i)
      (!reached) |=> (sep_o == $past(sep_o));
  endproperty
  a_sep_hold: assert property (p_sep_hold) else $error("separator toggled early"); // [R11]

endmodule : sync_separator

// ---- rtl/clamp_coast_sync_control_regs.sv ----
// clamp, coast, seek and power control registers with their sync-side logic
// Notes on behaviour
// R1: clamp source bit 0 uses internal hsync counters, 1 uses external clamp pin.
// R2: clamp polarity bit: 0 active high, 1 active low; external source only.
// R3: coast source bit: 0 uses coast pin, 1 uses vertical sync.
// R4: coast polarity override: 0 automatic, 1 uses written polarity bit.
// R5: coast polarity bit: 0 active low, 1 high; pin source with override only.
// R6: seek bit: 0 forbids seek, 1 enters seek whenever sync inputs are inactive.
// R7: seek mode tri-states sync, clock and data outputs; sync logic stays alive.
// R8: power bit is active low: 0 sleeps the chip, 1 runs normally.
// R9: power-down tri-states sync, clock and data outputs; registers stay active.
// R10: slicer threshold is a 5-bit field in bits 7:3, 10 mV per step.
// R11: separator counts 5 MHz ticks up to the 8-bit limit before toggling.
// R12: software sets separator limit above the widest expected sync pulse.
// R13: with vsync coast, coast rises the programmed line count before vsync.
// R14: with vsync coast, coast holds the programmed line count after vsync ends.
// R15: internal clamp starts after placement count, lasts duration count; zero illegal.
// R16: bit 0 of control and slicer registers reads zero and ignores writes.
// R17: control writes reach sync, clamp and coast logic at the next line start; with no sync present they pass straight through.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module clamp_coast_sync_control_regs
  import ccs_pkg::*;
(
  input wire logic clk_i, // 125 MHz clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic [7:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte lanes
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  input wire logic hsync_pin_i, // horizontal sync, active high
  input wire logic vsync_pin_i, // vertical sync, active high
  input wire logic clamp_pin_i, // external clamp
  input wire logic coast_pin_i, // external coast
  input wire logic sync_active_i, // sync detector: inputs active
  output logic clamp_o, // clamp pulse to the front end
  output logic coast_o, // pll coast, active high
  output logic sync_sep_o, // separated vertical sync
  output logic out_oe_n_o, // low while sync/clock/data outputs drive
  output logic [4:0] sog_level_o, // slicer threshold code
  output logic red_mid_o, // red clamps to red_midscale_reference
  output logic blue_mid_o // blue clamps to blue_midscale_reference
);

  // software-visible registers, then bus wait state and read data
  logic [7:0] ctrl_r;
  logic [7:0] slicer_r;
  logic [7:0] sep_limit_r;
  logic [7:0] lead_r;
  logic [7:0] trail_r;
  logic [7:0] place_r;
  logic [7:0] dur_r;
  logic waitreq_r;
  logic [31:0] rdata_r;

  // settings in force, loaded at line start
  cfg_t cfg_r;
  cfg_t cfg_nxt;

  // pin synchronisers, first stage read by second stage only
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic hs_d_r;
  logic vs_d_r;

  // clamp sequencer
  clamp_st_t cl_st_r;
  clamp_st_t cl_st_nxt;
  logic [7:0] cl_cnt_r;

  // coast tracking
  logic [7:0] lines_r;
  logic [7:0] frame_r;
  logic [7:0] post_r;
  logic auto_high_r;

  // bus decode
  wire [5:0] idx = avs_address_i[7:2];
  wire req = avs_read_i | avs_write_i;
  wire take = req & ~waitreq_r;
  wire wr_lo = take & avs_write_i & avs_byteenable_i[0];
  wire [7:0] wbyte = avs_writedata_i[7:0];
  wire hit_ctrl = (idx == IDX_CTRL);
  wire hit_slicer = (idx == IDX_SLICER);
  wire hit_sep = (idx == IDX_SEP_LIMIT);
  wire hit_lead = (idx == IDX_LEAD);
  wire hit_trail = (idx == IDX_TRAIL);
  wire hit_place = (idx == IDX_CLAMP_PLACE);
  wire hit_dur = (idx == IDX_CLAMP_DUR);
  wire [7:0] rd_byte = hit_ctrl ? ctrl_r :
                       hit_slicer ? slicer_r :
                       hit_sep ? sep_limit_r :
                       hit_lead ? lead_r :
                       hit_trail ? trail_r :
                       hit_place ? place_r :
                       hit_dur ? dur_r : 8'h00;

  // synchronised pins
  wire hs = pin_s2_r[0];
  wire vs = pin_s2_r[1];
  wire clamp_pin_s = pin_s2_r[2];
  wire coast_pin_s = pin_s2_r[3];
  wire hs_lead = hs & ~hs_d_r;
  wire hs_trail = ~hs & hs_d_r;
  wire vs_lead = vs & ~vs_d_r;
  wire vs_trail = ~vs & vs_d_r;

  // line boundary; with no sync present settings pass straight through
  wire load_cfg = hs_lead | ~sync_active_i; // [R17]

  always_comb begin
    cfg_nxt.clamp_ext = ctrl_r[B_CLAMP_EXT];
    cfg_nxt.clamp_pol_low = ctrl_r[B_CLAMP_POL_LOW];
    cfg_nxt.coast_vsync = ctrl_r[B_COAST_VSYNC];
    cfg_nxt.coast_pol_ovr = ctrl_r[B_COAST_POL_OVR];
    cfg_nxt.coast_pol_high = ctrl_r[B_COAST_POL_HIGH];
    cfg_nxt.seek_allow = ctrl_r[B_SEEK_ALLOW];
    cfg_nxt.chip_sleep_bit = ctrl_r[B_CHIP_SLEEP];
    cfg_nxt.slicer = slicer_r[B_SLICER_LSB +: W_SLICER];
    cfg_nxt.red_mid = slicer_r[B_RED_MID];
    cfg_nxt.blue_mid = slicer_r[B_BLUE_MID];
    cfg_nxt.sep_limit = sep_limit_r;
    cfg_nxt.lead = lead_r;
    cfg_nxt.trail = trail_r;
    cfg_nxt.place = place_r;
    cfg_nxt.dur = dur_r;
  end

  // clamp selection
  wire cl_place_done = (cl_st_r == CL_PLACE) && (cl_cnt_r >= cfg_r.place);
  wire cl_hold_done = (cl_st_r == CL_HOLD) && (cl_cnt_r >= cfg_r.dur);
  wire clamp_ext_act = clamp_pin_s ^ cfg_r.clamp_pol_low; // [R2]
  wire clamp_int_act = (cl_st_r == CL_HOLD);
  wire clamp_nxt = cfg_r.clamp_ext ? clamp_ext_act : clamp_int_act; // [R1]

  always_comb begin
    cl_st_nxt = cl_st_r;
    case (cl_st_r)
      CL_IDLE: begin
        if (hs_trail) begin
          cl_st_nxt = CL_PLACE;
        end
      end
      CL_PLACE: begin
        if (cl_place_done) begin
          cl_st_nxt = CL_HOLD; // [R15]
        end
      end
      CL_HOLD: begin
        if (cl_hold_done) begin
          cl_st_nxt = CL_IDLE; // [R15]
        end
      end
      default: begin
        cl_st_nxt = CL_IDLE;
      end
    endcase
  end

  // coast selection
  wire pol_high = cfg_r.coast_pol_ovr ? cfg_r.coast_pol_high : auto_high_r; // [R4]
  wire coast_pin_act = (coast_pin_s == pol_high); // [R5]
  wire [8:0] lines_ahead = {1'b0, lines_r} + {1'b0, cfg_r.lead};
  wire pre_act = (cfg_r.lead != 8'h00) && (frame_r != 8'h00) &&
                 (lines_ahead >= {1'b0, frame_r}); // [R13]
  wire post_act = (post_r != 8'h00); // [R14]
  wire coast_v_act = vs | pre_act | post_act;
  wire coast_nxt = cfg_r.coast_vsync ? coast_v_act : coast_pin_act; // [R3]

  // output tri-state control
  wire sleeping = ~cfg_r.chip_sleep_bit; // [R8]
  wire seeking = cfg_r.seek_allow & ~sync_active_i; // [R6]
  wire oe_n_nxt = sleeping | seeking; // [R7] [R9]

  // register file
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= RST_CTRL;
      slicer_r <= RST_SLICER;
      sep_limit_r <= RST_SEP_LIMIT;
      lead_r <= RST_LEAD;
      trail_r <= RST_TRAIL;
      place_r <= RST_CLAMP_PLACE;
      dur_r <= RST_CLAMP_DUR;
    end else if (wr_lo) begin
      if (hit_ctrl) begin
        ctrl_r <= {wbyte[7:1], 1'b0}; // [R16]
      end
      if (hit_slicer) begin
        slicer_r <= {wbyte[7:1], 1'b0}; // [R16] [R10]
      end
      if (hit_sep) begin
        sep_limit_r <= wbyte;
      end
      if (hit_lead) begin
        lead_r <= wbyte;
      end
      if (hit_trail) begin
        trail_r <= wbyte;
      end
      if (hit_place) begin
        place_r <= wbyte;
      end
      if (hit_dur) begin
        dur_r <= wbyte;
      end
    end
  end

  // one wait state per access
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      waitreq_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      waitreq_r <= ~(req & waitreq_r);
      if (req & waitreq_r) begin
        rdata_r <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      hs_d_r <= 1'b0;
      vs_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {coast_pin_i, clamp_pin_i, vsync_pin_i, hsync_pin_i};
      pin_s2_r <= pin_s1_r;
      hs_d_r <= hs;
      vs_d_r <= vs;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_r <= '0;
      cfg_r.chip_sleep_bit <= RST_CTRL[B_CHIP_SLEEP];
    end else if (load_cfg) begin
      cfg_r <= cfg_nxt; // [R17]
    end
  end

  // clamp counter runs in clock periods
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cl_st_r <= CL_IDLE;
      cl_cnt_r <= 8'h00;
    end else begin
      cl_st_r <= cl_st_nxt;
      if (cl_st_nxt != cl_st_r) begin
        cl_cnt_r <= 8'h01;
      end else if (cl_cnt_r != 8'hff) begin
        cl_cnt_r <= cl_cnt_r + 8'h01;
      end
    end
  end

  // lines per frame, lines since vsync, post-coast countdown
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lines_r <= 8'h00;
      frame_r <= 8'h00;
      post_r <= 8'h00;
      auto_high_r <= 1'b1;
    end else begin
      if (vs_lead) begin
        frame_r <= lines_r;
        lines_r <= 8'h00;
      end else if (hs_lead && lines_r != 8'hff) begin
        lines_r <= lines_r + 8'h01;
      end
      if (vs_trail) begin
        post_r <= cfg_r.trail; // [R14]
      end else if (hs_lead && post_act) begin
        post_r <= post_r - 8'h01;
      end
      if (hs_lead) begin
        auto_high_r <= ~coast_pin_s; // active high if the pin idles low at line start
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clamp_o <= 1'b0;
      coast_o <= 1'b0;
      out_oe_n_o <= 1'b1;
      sog_level_o <= 5'h00;
      red_mid_o <= 1'b0;
      blue_mid_o <= 1'b0;
    end else begin
      clamp_o <= clamp_nxt;
      coast_o <= coast_nxt;
      out_oe_n_o <= oe_n_nxt;
      sog_level_o <= cfg_r.slicer; // [R10]
      red_mid_o <= cfg_r.red_mid;
      blue_mid_o <= cfg_r.blue_mid;
    end
  end

  assign avs_waitrequest_o = waitreq_r;
  assign avs_readdata_o = rdata_r;

  sync_separator #(
    .DIV(SEP_DIV)
  ) u_sep (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .sync_i(hs),
    .limit_i(cfg_r.sep_limit), // [R11]
    .sep_o(sync_sep_o)
  );

  property p_clamp_ext_high;
    @(posedge clk_i) disable iff (!arst_n_i)
      (cfg_r.clamp_ext && !cfg_r.clamp_pol_low) |=> (clamp_o == $past(clamp_pin_s));
  endproperty
  a_clamp_ext_high: assert property (p_clamp_ext_high) else $error("ext clamp wrong"); // [R1]

  property p_clamp_ext_low;
    @(posedge clk_i) disable iff (!arst_n_i)
      (cfg_r.clamp_ext && cfg_r.clamp_pol_low) |=> (clamp_o != $past(clamp_pin_s));
  endproperty
  a_clamp_ext_low: assert property (p_clamp_ext_low) else $error("clamp polarity wrong"); // [R2]

  sequence s_hold_start;
    (cl_st_r == CL_PLACE) && cl_place_done;
  endsequence
  sequence s_clamp_on;
    (cl_st_r == CL_HOLD) ##1 (clamp_o || cfg_r.clamp_ext);
  endsequence
  property p_clamp_int;
    @(posedge clk_i) disable iff (!arst_n_i)
      s_hold_start |=> s_clamp_on;
  endproperty
  a_clamp_int: assert property (p_clamp_int) else $error("internal clamp missing"); // [R15]

  property p_coast_pin;
    @(posedge clk_i) disable iff (!arst_n_i)
      (!cfg_r.coast_vsync && cfg_r.coast_pol_ovr && cfg_r.coast_pol_high)
        |=> (coast_o == $past(coast_pin_s));
  endproperty
  a_coast_pin: assert property (p_coast_pin) else $error("coast pin select wrong"); // [R3] [R5]

  property p_coast_auto;
    @(posedge clk_i) disable iff (!arst_n_i)
      (!cfg_r.coast_vsync && !cfg_r.coast_pol_ovr)
        |=> (coast_o == ($past(coast_pin_s) == $past(auto_high_r)));
  endproperty
  a_coast_auto: assert property (p_coast_auto) else $error("coast auto polarity wrong"); // [R4]

  property p_coast_vs;
    @(posedge clk_i) disable iff (!arst_n_i)
      (cfg_r.coast_vsync && (vs || pre_act)) |=> coast_o;
  endproperty
  a_coast_vs: assert property (p_coast_vs) else $error("vsync coast missing"); // [R13]

  property p_post_load;
    @(posedge clk_i) disable iff (!arst_n_i)
      vs_trail |=> (post_r == $past(cfg_r.trail));
  endproperty
  a_post_load: assert property (p_post_load) else $error("post coast not loaded"); // [R14]

  property p_sleep;
    @(posedge clk_i) disable iff (!arst_n_i)
      !cfg_r.chip_sleep_bit |=> out_oe_n_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("outputs driven in power-down"); // [R8] [R9]

  property p_seek;
    @(posedge clk_i) disable iff (!arst_n_i)
      (cfg_r.seek_allow && !sync_active_i) |=> out_oe_n_o;
  endproperty
  a_seek: assert property (p_seek) else $error("outputs driven in seek"); // [R6] [R7]

  property p_run;
    @(posedge clk_i) disable iff (!arst_n_i)
      (cfg_r.chip_sleep_bit && (!cfg_r.seek_allow || sync_active_i)) |=> !out_oe_n_o;
  endproperty
  a_run: assert property (p_run) else $error("outputs idle in normal run"); // [R6]

  property p_cfg_hold;
    @(posedge clk_i) disable iff (!arst_n_i)
      !load_cfg |=> (cfg_r == $past(cfg_r));
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("settings changed mid-line"); // [R17]

  property p_bit0_zero;
    @(posedge clk_i) disable iff (!arst_n_i)
      (req && waitreq_r && (hit_ctrl || hit_slicer)) |=> (avs_readdata_o[0] == 1'b0);
  endproperty
  a_bit0_zero: assert property (p_bit0_zero) else $error("reserved bit reads one"); // [R16]

  property p_slicer;
    @(posedge clk_i) disable iff (!arst_n_i)
      1'b1 |=> (sog_level_o == $past(cfg_r.slicer));
  endproperty
  a_slicer: assert property (p_slicer) else $error("slicer code wrong"); // [R10]

endmodule : clamp_coast_sync_control_regs

// ---- testbench/tb_clamp_coast_sync_control_regs.sv ----
// testbench: register access, output enable and sync-side checks for the control block
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module tb_clamp_coast_sync_control_regs;
  import ccs_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic hsync_pin_i = 1'b0;
  logic vsync_pin_i = 1'b0;
  logic clamp_pin_i = 1'b0;
  logic coast_pin_i = 1'b0;
  logic sync_active_i = 1'b0;
  logic clamp_o, coast_o, sync_sep_o, out_oe_n_o, red_mid_o, blue_mid_o;
  logic [4:0] sog_level_o;
  int mismatches = 0;
  int num_checks = 0;
  integer seed = 32'ha9b5;
  logic [31:0] rd;
  logic [5:0] ix [7] = '{6'h05, 6'h06, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h13};
  logic [7:0] sh [7] = '{8'h08, 8'h14, 8'h4e, 8'h78, 8'h20, 8'h00, 8'h00};
  logic [7:0] d;
  logic [3:0] be;
  logic v;
  int k;
  int w;

  clamp_coast_sync_control_regs dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .hsync_pin_i(hsync_pin_i),
    .vsync_pin_i(vsync_pin_i), .clamp_pin_i(clamp_pin_i), .coast_pin_i(coast_pin_i),
    .sync_active_i(sync_active_i), .clamp_o(clamp_o), .coast_o(coast_o),
    .sync_sep_o(sync_sep_o), .out_oe_n_o(out_oe_n_o), .sog_level_o(sog_level_o),
    .red_mid_o(red_mid_o), .blue_mid_o(blue_mid_o)
  );

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task summarize;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // one avalon access; request held until waitrequest is sampled low
  task bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd, input logic [3:0] ben);
    int n;
    n = 0;
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {24'($random(seed)), wd};
    avs_byteenable_i <= ben;
    if (wr) begin
      avs_write_i <= 1'b1;
    end else begin
      avs_read_i <= 1'b1;
    end
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) begin
      mismatches++;
      summarize();
    end
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task wr_reg(input logic [5:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd, 4'hf);
  endtask : wr_reg

  task rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'hf);
    `CHK(rd, {24'h00_0000, exp})
  endtask : rd_chk

  function automatic logic [7:0] stored(input logic [5:0] idx, input logic [7:0] wd);
    return (idx == 6'h0f || idx == 6'h10) ? (wd & 8'hfe) : wd;
  endfunction : stored

  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task hline(input int hi, input int per);
    hsync_pin_i <= 1'b1;
    cyc(hi);
    hsync_pin_i <= 1'b0;
    cyc(per - hi);
  endtask : hline

  initial begin
    cyc(100000);
    mismatches++;
    summarize();
  end

  initial begin
    cyc(10);
    arst_n_i <= 1'b1;
    cyc(4);
    for (int i = 0; i < 7; i++) rd_chk(ix[i], sh[i]);
    rd_chk(6'h00, 8'h00);
    rd_chk(6'h3f, 8'h00);
    `CHK(out_oe_n_o, 1'b1)
    `CHK(sog_level_o, 5'h0f)
    for (int i = 0; i < 24; i++) begin
      k = $unsigned($random(seed)) % 7;
      d = 8'($random(seed));
      be = (i % 3 == 0) ? 4'he : 4'($random(seed));
      bus(1'b1, ix[k], d, be);
      if (be[0]) sh[k] = stored(ix[k], d);
      rd_chk(ix[k], sh[k]);
    end
    wr_reg(6'h0f, 8'hff);
    rd_chk(6'h0f, 8'hfe);
    // output enable: seek and power-down
    wr_reg(6'h0f, 8'h06);
    sync_active_i <= 1'b1;
    hline(4, 20);
    cyc(4);
    `CHK(out_oe_n_o, 1'b0)
    sync_active_i <= 1'b0;
    cyc(6);
    `CHK(out_oe_n_o, 1'b1)
    wr_reg(6'h0f, 8'h02);
    cyc(4);
    `CHK(out_oe_n_o, 1'b0)
    wr_reg(6'h0f, 8'h00);
    cyc(4);
    `CHK(out_oe_n_o, 1'b1)
    wr_reg(6'h0f, 8'h02);
    cyc(4);
    `CHK(out_oe_n_o, 1'b0)
    // slicer field and clamp reference selects
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'h00 : (i == 5) ? 8'hf8 : 8'($random(seed));
      wr_reg(6'h10, d);
      cyc(4);
      `CHK({sog_level_o, red_mid_o, blue_mid_o}, d[7:1])
    end
    // settings held until the next line start while sync is active
    sync_active_i <= 1'b1;
    hline(4, 20);
    wr_reg(6'h10, 8'h50);
    cyc(8);
    `CHK(sog_level_o, 5'h1f)
    hline(4, 20);
    `CHK(sog_level_o, 5'h0a)
    sync_active_i <= 1'b0;
    // external clamp pin and polarity
    for (int p = 0; p < 2; p++) begin
      wr_reg(6'h0f, 8'h82 | 8'(p << 6));
      for (int i = 0; i < 4; i++) begin
        v = (i < 2) ? i[0] : 1'($random(seed));
        clamp_pin_i <= v;
        cyc(6);
        `CHK(clamp_o, v ^ p[0])
      end
    end
    // coast pin with written polarity
    for (int p = 0; p < 2; p++) begin
      wr_reg(6'h0f, 8'h12 | 8'(p << 3));
      for (int i = 0; i < 4; i++) begin
        v = (i < 2) ? i[0] : 1'($random(seed));
        coast_pin_i <= v;
        cyc(6);
        `CHK(coast_o, p[0] ? v : ~v)
      end
    end
    // internal clamp duration, after a placement of 4 counted from the hsync trailing edge
    wr_reg(6'h0f, 8'h02);
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 8'h01 : 8'(1 + $unsigned($random(seed)) % 20);
      wr_reg(6'h05, 8'h04);
      wr_reg(6'h06, d);
      w = 0;
      fork
        hline(4, 60);
        repeat (60) begin
          @(posedge clk_i);
          if (clamp_o === 1'b1) w++;
        end
      join
      `CHK(w, 32'(d))
    end
    // separator: limit of two 5 MHz ticks
    wr_reg(6'h11, 8'h02);
    for (int i = 1; i >= 0; i--) begin
      hsync_pin_i <= i[0];
      cyc(20);
      `CHK(sync_sep_o, ~i[0])
      cyc(70);
      `CHK(sync_sep_o, i[0])
    end
    // vertical sync as coast source with a trailing hold of three lines
    wr_reg(6'h12, 8'h00);
    wr_reg(6'h13, 8'h03);
    wr_reg(6'h0f, 8'h22);
    vsync_pin_i <= 1'b1;
    hline(4, 20);
    hline(4, 20);
    `CHK(coast_o, 1'b1)
    vsync_pin_i <= 1'b0;
    hline(4, 20);
    hline(4, 20);
    `CHK(coast_o, 1'b1)
    hline(4, 20);
    hline(4, 20);
    `CHK(coast_o, 1'b0)
    // pre-coast: frame of six lines, coast two lines ahead of vsync
    wr_reg(6'h13, 8'h00);
    wr_reg(6'h12, 8'h02);
    for (int f = 0; f < 2; f++) begin
      vsync_pin_i <= 1'b1;
      hline(4, 20);
      vsync_pin_i <= 1'b0;
      if (f == 0) repeat (6) hline(4, 20);
    end
    repeat (3) hline(4, 20);
    `CHK(coast_o, 1'b0)
    hline(4, 20);
    `CHK(coast_o, 1'b1)
    cyc(10);
    summarize();
  end
endmodule : tb_clamp_coast_sync_control_regs
